// *** src/mepr_map.svh ***
// Register offsets, field positions, reset values and source layouts of the event pin router
`ifndef MEPR_MAP_SVH
`define MEPR_MAP_SVH

// ----------------------------------------------------------------------------
// Byte offsets
// ----------------------------------------------------------------------------
`define MEPR_OFF_A_DATA    8'h00
`define MEPR_OFF_A_MOTION  8'h04
`define MEPR_OFF_B_DATA    8'h08
`define MEPR_OFF_B_MOTION  8'h0c
`define MEPR_OFF_CTRL      8'h10
`define MEPR_OFF_SRC_WU    8'h14
`define MEPR_OFF_SRC_OR    8'h18
`define MEPR_OFF_SRC_TAP   8'h1c
`define MEPR_OFF_SRC_F1    8'h20
`define MEPR_OFF_SRC_F2    8'h24
`define MEPR_OFF_IRQ_STAT  8'h28
`define MEPR_OFF_IRQ_MASK  8'h2c

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define MEPR_RST_ROUTE     8'h00
`define MEPR_RST_CTRL      8'h00
`define MEPR_RST_IRQ       3'h0

// ----------------------------------------------------------------------------
// Event vector groups (bit 0 timer .. bit 12 step window)
// ----------------------------------------------------------------------------
`define MEPR_EV_BASIC      13'h00fc
`define MEPR_EV_CLR_WU     13'h00b0
`define MEPR_EV_CLR_OR     13'h0004
`define MEPR_EV_CLR_TAP    13'h0048
`define MEPR_EV_CLR_F1     13'h1e03
`define MEPR_EV_CLR_F2     13'h0100

`endif

// *** src/mepr_pkg.sv ***
// Types shared by the event pin router
package mepr_pkg;

    // Global control register, bit 7 downward
    typedef struct packed {
        logic den_active_high;
        logic den_latched_mode;
        logic basic_events_enable;
        logic gate_ready_on_pin_a;
        logic merge_pins;
        logic event_latch_enable;
        logic pin_drive_open;
        logic pin_polarity_low;
    } mepr_ctrl_s;

    // Live data and queue conditions
    typedef struct packed {
        logic temp_ready;
        logic queue_full;
        logic queue_overrun;
        logic queue_threshold;
        logic boot;
        logic gyro_ready;
        logic accel_ready;
    } mepr_data_s;

    // Detector events, timer at bit 0
    typedef struct packed {
        logic step_window;
        logic step_wrap;
        logic significant_motion;
        logic step;
        logic magnetic_correction;
        logic inactivity;
        logic single_tap;
        logic wakeup;
        logic freefall;
        logic double_tap;
        logic orientation;
        logic tilt;
        logic timer;
    } mepr_events_s;

    // Mark pulse ready sequencer
    typedef enum logic [1:0] {
        MEPR_DEN_IDLE  = 2'b00,
        MEPR_DEN_ARMED = 2'b01,
        MEPR_DEN_FIRE  = 2'b11
    } mepr_den_e;

endpackage

// *** src/mepr_pin_drive.sv ***
// Output stage of one event pin: polarity and drive mode
`timescale 1ns/1ps
module mepr_pin_drive
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // Control
    input  wire logic asserted,
    input  wire logic polarity_low,
    input  wire logic drive_open,
    // Pin
    output logic      pin_out,
    output logic      pin_oe
);
    logic pin_out_next;
    logic pin_oe_next;

    assign pin_out_next = asserted ^ polarity_low;
    assign pin_oe_next  = ~drive_open | asserted;

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            pin_out <= 1'b0;
            pin_oe  <= 1'b1;
        end
        else
        begin
            pin_out <= pin_out_next;
            pin_oe  <= pin_oe_next;
        end
    end
endmodule

// *** src/mepr_router.sv ***
// Event pin router: route masks, latching, mark pulse and APB registers
`timescale 1ns/1ps
`include "mepr_map.svh"
module mepr_router
#(
    parameter int EV_W = 13
)
(
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Sources
    input  wire mepr_pkg::mepr_data_s   data_in,
    input  wire mepr_pkg::mepr_events_s events_in,
    input  wire logic                  accel_active,
    input  wire logic                  sample_mark_input,
    // Pins
    output logic                       event_pin_a_out,
    output logic                       event_pin_a_oe,
    output logic                       event_pin_b_out,
    output logic                       event_pin_b_oe,
    // Interrupt
    output logic                       irq
);
    import mepr_pkg::*;

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    logic [7:0]       a_data_reg;
    logic [7:0]       a_motion_reg;
    logic [7:0]       b_data_reg;
    logic [7:0]       b_motion_reg;
    mepr_ctrl_s       ctrl_reg;
    logic [2:0]       irq_stat_reg;
    logic [2:0]       irq_mask_reg;
    logic [2:0]       irq_stat_next;
    logic [EV_W-1:0]  held_reg;
    logic [EV_W-1:0]  held_next;
    logic [31:0]      prdata_next;
    logic             mark_sync1_reg;
    logic             mark_sync2_reg;
    logic             mark_act_reg;
    mepr_den_e        den_reg;
    mepr_den_e        den_next;
    logic             accel_rdy_reg;
    logic             assert_a_reg;
    logic             assert_b_reg;

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    wire access_req  = psel & penable & ~pready;
    wire access_done = psel & penable & pready;
    wire wr_done     = access_done & pwrite;
    wire rd_done     = access_done & ~pwrite;
    wire sel_a_data  = paddr == `MEPR_OFF_A_DATA;
    wire sel_a_mot   = paddr == `MEPR_OFF_A_MOTION;
    wire sel_b_data  = paddr == `MEPR_OFF_B_DATA;
    wire sel_b_mot   = paddr == `MEPR_OFF_B_MOTION;
    wire sel_ctrl    = paddr == `MEPR_OFF_CTRL;
    wire sel_wu      = paddr == `MEPR_OFF_SRC_WU;
    wire sel_or      = paddr == `MEPR_OFF_SRC_OR;
    wire sel_tap     = paddr == `MEPR_OFF_SRC_TAP;
    wire sel_f1      = paddr == `MEPR_OFF_SRC_F1;
    wire sel_f2      = paddr == `MEPR_OFF_SRC_F2;
    wire sel_istat   = paddr == `MEPR_OFF_IRQ_STAT;
    wire sel_imask   = paddr == `MEPR_OFF_IRQ_MASK;
    wire sel_any     = sel_a_data | sel_a_mot | sel_b_data | sel_b_mot | sel_ctrl
                     | sel_wu | sel_or | sel_tap | sel_f1 | sel_f2 | sel_istat | sel_imask;

    // ------------------------------------------------------------------------
    // Event qualification and latching
    // ------------------------------------------------------------------------
    // Detectors see accelerometer data only, so a sleeping accelerometer silences them
    wire [EV_W-1:0] ev_raw   = events_in;
    wire [EV_W-1:0] ev_basic = ctrl_reg.basic_events_enable ? {EV_W{1'b1}}
                                                            : ~`MEPR_EV_BASIC;
    wire [EV_W-1:0] ev_live  = ev_raw & ev_basic & {EV_W{accel_active}};

    // A source register read clears only the flags it reports
    wire [EV_W-1:0] ev_clear = ({EV_W{rd_done & sel_wu}}  & `MEPR_EV_CLR_WU)
                             | ({EV_W{rd_done & sel_or}}  & `MEPR_EV_CLR_OR)
                             | ({EV_W{rd_done & sel_tap}} & `MEPR_EV_CLR_TAP)
                             | ({EV_W{rd_done & sel_f1}}  & `MEPR_EV_CLR_F1)
                             | ({EV_W{rd_done & sel_f2}}  & `MEPR_EV_CLR_F2);

    genvar gi;
    generate
        for (gi = 0; gi < EV_W; gi++)
        begin : g_held
            // A new event in the clearing cycle survives
            assign held_next[gi] = ev_live[gi] | (held_reg[gi] & ~ev_clear[gi]);
        end
    endgenerate

    // Flags seen by software, routed or not
    wire [EV_W-1:0] ev_seen = held_reg | ev_live;
    // Latch applies only on the pin path; unrouted events never hold a pin
    wire [EV_W-1:0] ev_pin  = ctrl_reg.event_latch_enable ? ev_seen : ev_live;
    wire mepr_events_s ev_p = ev_pin;

    // ------------------------------------------------------------------------
    // Mark pulse and gated data ready
    // ------------------------------------------------------------------------
    wire mark_act  = ctrl_reg.den_active_high ? mark_sync2_reg : ~mark_sync2_reg;
    wire mark_end  = mark_act_reg & ~mark_act;
    wire gate_mode = ctrl_reg.den_latched_mode & ctrl_reg.gate_ready_on_pin_a;
    wire sample_new = data_in.accel_ready & ~accel_rdy_reg;
    wire den_pulse = den_reg == MEPR_DEN_FIRE;

    always_comb
    begin
        den_next = den_reg;
        case (den_reg)
            MEPR_DEN_IDLE:
                if (gate_mode && mark_end)
                    den_next = MEPR_DEN_ARMED;
            MEPR_DEN_ARMED:
                if (!gate_mode)
                    den_next = MEPR_DEN_IDLE;
                else if (sample_new)
                    den_next = MEPR_DEN_FIRE;
            MEPR_DEN_FIRE:
                den_next = MEPR_DEN_IDLE;
            default:
                den_next = MEPR_DEN_IDLE;
        endcase
    end

    // ------------------------------------------------------------------------
    // Routing
    // ------------------------------------------------------------------------
    // In gated mode the plain ready lines of the pin A route yield pin A to the single mark pulse; with merge_pins, pin B ready routes still reach it
    wire rdy_a_on = ~gate_mode;

    wire [7:0] a_data_src = {ev_p.step, ev_p.significant_motion, data_in.queue_full,
                             data_in.queue_overrun, data_in.queue_threshold, data_in.boot,
                             data_in.gyro_ready & rdy_a_on,
                             data_in.accel_ready & rdy_a_on};
    wire [7:0] a_mot_src  = ev_pin[7:0];
    wire [7:0] b_data_src = {ev_p.step_window, ev_p.step_wrap, data_in.queue_full,
                             data_in.queue_overrun, data_in.queue_threshold,
                             data_in.temp_ready, data_in.gyro_ready,
                             data_in.accel_ready};
    wire [7:0] b_mot_src  = {ev_pin[7:1], ev_p.magnetic_correction};

    wire hit_a = |(a_data_src & a_data_reg) | |(a_mot_src & a_motion_reg)
               | den_pulse;
    wire hit_b = |(b_data_src & b_data_reg) | |(b_mot_src & b_motion_reg);
    wire assert_a_next = hit_a | (ctrl_reg.merge_pins & hit_b);
    wire assert_b_next = hit_b & ~ctrl_reg.merge_pins;

    // ------------------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------------------
    wire [2:0] irq_set = {den_pulse, assert_b_next & ~assert_b_reg,
                          assert_a_next & ~assert_a_reg};
    wire [2:0] irq_clr = (wr_done & sel_istat) ? pwdata[2:0] : 3'h0;
    assign irq_stat_next = irq_set | (irq_stat_reg & ~irq_clr);
    wire irq_next = |(irq_stat_next & irq_mask_reg);

    // ------------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------------
    always_comb
    begin
        prdata_next = 32'h0000_0000;
        case (1'b1)
            sel_a_data: prdata_next[7:0] = a_data_reg;
            sel_a_mot:  prdata_next[7:0] = a_motion_reg;
            sel_b_data: prdata_next[7:0] = b_data_reg;
            sel_b_mot:  prdata_next[7:0] = b_motion_reg;
            sel_ctrl:   prdata_next[7:0] = ctrl_reg;
            sel_wu:     prdata_next[2:0] = {ev_seen[7], ev_seen[5], ev_seen[4]};
            sel_or:     prdata_next[0]   = ev_seen[2];
            sel_tap:    prdata_next[1:0] = {ev_seen[3], ev_seen[6]};
            sel_f1:     prdata_next[5:0] = {ev_seen[0], ev_seen[12:9], ev_seen[1]};
            sel_f2:     prdata_next[0]   = ev_seen[8];
            sel_istat:  prdata_next[2:0] = irq_stat_reg;
            sel_imask:  prdata_next[2:0] = irq_mask_reg;
            default:    prdata_next = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------------------
    // Bus slave flops
    // ------------------------------------------------------------------------
    // One wait state so read data and the error flag come from flops
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= access_req;
            pslverr <= access_req & ~sel_any;
            prdata  <= (access_req & ~pwrite) ? prdata_next : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            a_data_reg   <= `MEPR_RST_ROUTE;
            a_motion_reg <= `MEPR_RST_ROUTE;
            b_data_reg   <= `MEPR_RST_ROUTE;
            b_motion_reg <= `MEPR_RST_ROUTE;
            ctrl_reg     <= `MEPR_RST_CTRL;
            irq_mask_reg <= `MEPR_RST_IRQ;
        end
        else if (wr_done)
        begin
            if (sel_a_data)
                a_data_reg <= pwdata[7:0];
            if (sel_a_mot)
                a_motion_reg <= pwdata[7:0];
            if (sel_b_data)
                b_data_reg <= pwdata[7:0];
            if (sel_b_mot)
                b_motion_reg <= pwdata[7:0];
            if (sel_ctrl)
                ctrl_reg <= pwdata[7:0];
            if (sel_imask)
                irq_mask_reg <= pwdata[2:0];
        end
    end

    // ------------------------------------------------------------------------
    // Event, sequencer and pin state
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            held_reg     <= '0;
            irq_stat_reg <= `MEPR_RST_IRQ;
            irq          <= 1'b0;
            den_reg      <= MEPR_DEN_IDLE;
            accel_rdy_reg <= 1'b0;
            assert_a_reg <= 1'b0;
            assert_b_reg <= 1'b0;
        end
        else
        begin
            held_reg     <= held_next;
            irq_stat_reg <= irq_stat_next;
            irq          <= irq_next;
            den_reg      <= den_next;
            accel_rdy_reg <= data_in.accel_ready;
            assert_a_reg <= assert_a_next;
            assert_b_reg <= assert_b_next;
        end
    end

    // Mark pin comes from outside, two flops before use
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            // Idle level of the default active-low mark, so leaving reset gives no false end
            mark_sync1_reg <= 1'b1;
            mark_sync2_reg <= 1'b1;
            mark_act_reg   <= 1'b0;
        end
        else
        begin
            mark_sync1_reg <= sample_mark_input;
            mark_sync2_reg <= mark_sync1_reg;
            mark_act_reg   <= mark_act;
        end
    end

    // ------------------------------------------------------------------------
    // Pin stages
    // ------------------------------------------------------------------------
    mepr_pin_drive u_pin_a
    (
        .mclk         (mclk),
        .rst_n        (rst_n),
        .asserted     (assert_a_reg),
        .polarity_low (ctrl_reg.pin_polarity_low),
        .drive_open   (ctrl_reg.pin_drive_open),
        .pin_out      (event_pin_a_out),
        .pin_oe       (event_pin_a_oe)
    );

    mepr_pin_drive u_pin_b
    (
        .mclk         (mclk),
        .rst_n        (rst_n),
        .asserted     (assert_b_reg),
        .polarity_low (ctrl_reg.pin_polarity_low),
        .drive_open   (ctrl_reg.pin_drive_open),
        .pin_out      (event_pin_b_out),
        .pin_oe       (event_pin_b_oe)
    );
endmodule

// *** verification/mepr_host_lines.sv ***
// Host side of the two event lines: board pull and line resolution
`timescale 1ns/1ps
module mepr_host_lines
(
    // Pins from the device
    input  wire logic pin_a_out,
    input  wire logic pin_a_oe,
    input  wire logic pin_b_out,
    input  wire logic pin_b_oe,
    // Board pull, fitted at the idle level of the pins
    input  wire logic pull_high,
    // Levels the host sees
    output wire logic line_a,
    output wire logic line_b
);
    // A released line shows the pull, never the last driven value
    assign line_a = pin_a_oe ? pin_a_out : pull_high;
    assign line_b = pin_b_oe ? pin_b_out : pull_high;
endmodule

// *** verification/mepr_router_props.sv ***
// Port-level assertions for the event pin router
`timescale 1ns/1ps
`include "mepr_map.svh"
module mepr_router_props
    import mepr_pkg::*;
#(
    parameter int EV_W = 13
)
(
    // Clock, reset and bus
    input wire logic                 mclk,
    input wire logic                 rst_n,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [7:0]           paddr,
    input wire logic [31:0]          pwdata,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    // Sources and pins
    input wire mepr_pkg::mepr_data_s data_in,
    input wire logic                 accel_active,
    input wire logic                 event_pin_a_out,
    input wire logic                 event_pin_a_oe,
    input wire logic                 event_pin_b_out,
    input wire logic                 event_pin_b_oe,
    input wire logic                 irq
);
    // Control shadow; pin stages lag a control write, so checks wait three edges
    mepr_ctrl_s ctrl_sh;
    logic [1:0] age;
    wire        ctrl_wr = psel && penable && pwrite && pready && (paddr == `MEPR_OFF_CTRL);
    wire        settled = (age == 2'd3);
    wire        pol     = ctrl_sh.pin_polarity_low;

    always_ff @(posedge mclk)
    begin
        ctrl_sh <= !rst_n ? mepr_ctrl_s'(8'h00) : (ctrl_wr ? mepr_ctrl_s'(pwdata[7:0]) : ctrl_sh);
        age     <= (!rst_n || ctrl_wr) ? 2'd0 : (settled ? age : age + 2'd1);
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_ans; psel && penable && !pready |=> pready; endproperty
    a_ans: assert property (p_ans) else $error("no answer one cycle after the access edge");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("ready held longer than one cycle");
    property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
    a_err: assert property (p_err) else $error("error answer without ready or with data");
    property p_idle; !pready |-> prdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data not zero outside an answer");
    property p_rst;
        disable iff (1'b0) !rst_n |=> !event_pin_a_out && event_pin_a_oe && !event_pin_b_out && event_pin_b_oe && !irq;
    endproperty
    a_rst: assert property (p_rst) else $error("pins or irq not idle after reset");
    property p_push; settled && !ctrl_sh.pin_drive_open |-> event_pin_a_oe && event_pin_b_oe; endproperty
    a_push: assert property (p_push) else $error("push-pull pin not driven");
    property p_open;
        settled && ctrl_sh.pin_drive_open |-> event_pin_a_oe == (event_pin_a_out != pol)
            && event_pin_b_oe == (event_pin_b_out != pol);
    endproperty
    a_open: assert property (p_open) else $error("open-drain pin drives its idle level");
    property p_merge; settled && ctrl_sh.merge_pins |-> event_pin_b_out == pol && !event_pin_b_oe == ctrl_sh.pin_drive_open;
    endproperty
    a_merge: assert property (p_merge) else $error("pin b asserted while merged");
    property p_quiet;
        (!accel_active && data_in == 7'h00)[*3] ##0 (settled && !ctrl_sh.event_latch_enable
            && !ctrl_sh.gate_ready_on_pin_a) |-> event_pin_a_out == pol && event_pin_b_out == pol;
    endproperty
    a_quiet: assert property (p_quiet) else $error("pin asserted with accelerometer idle");
endmodule

bind mepr_router mepr_router_props #(.EV_W(EV_W)) i_mepr_router_props (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .data_in(data_in),
    .accel_active(accel_active), .event_pin_a_out(event_pin_a_out), .event_pin_a_oe(event_pin_a_oe),
    .event_pin_b_out(event_pin_b_out), .event_pin_b_oe(event_pin_b_oe), .irq(irq));

// *** verification/tb.sv ***
// Self-checking bench for the event pin router
`timescale 1ns/1ps
`include "mepr_map.svh"
module tb;
    import mepr_pkg::*;
    typedef struct packed {
        logic [7:0]  ad, am, bd, bm, ctl;
        logic [6:0]  dat;
        logic [12:0] ev;
        logic        ea, eb;
    } mepr_row_s;
    // Routes, control and live inputs beside the pin states they must give
    localparam mepr_row_s ROWS [11] = '{
        '{8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 7'h7f, 13'h1fff, 1'b0, 1'b0},
        '{8'h00, 8'h10, 8'h00, 8'h00, 8'h20, 7'h00, 13'h0010, 1'b1, 1'b0},
        '{8'h01, 8'h00, 8'h80, 8'h00, 8'h20, 7'h01, 13'h1000, 1'b1, 1'b1},
        '{8'h00, 8'h00, 8'h00, 8'h01, 8'h21, 7'h00, 13'h0100, 1'b0, 1'b1},
        '{8'h00, 8'h01, 8'h00, 8'h01, 8'h22, 7'h00, 13'h0001, 1'b1, 1'b0},
        '{8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 7'h00, 13'h0010, 1'b0, 1'b0},
        '{8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 7'h00, 13'h0002, 1'b1, 1'b0},
        '{8'h00, 8'h00, 8'h00, 8'h10, 8'h28, 7'h00, 13'h0010, 1'b1, 1'b0},
        '{8'hfe, 8'h00, 8'h00, 8'h00, 8'h23, 7'h20, 13'h0000, 1'b1, 1'b0},
        '{8'h80, 8'h00, 8'h00, 8'h00, 8'h20, 7'h00, 13'h0200, 1'b1, 1'b0},
        '{8'h00, 8'h00, 8'h04, 8'h00, 8'h20, 7'h40, 13'h0000, 1'b0, 1'b1}};

    logic         mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]   paddr = 8'h00;
    logic [31:0]  pwdata = 32'h0, prdata, rd_val;
    logic         accel_active = 1'b1, sample_mark_input = 1'b1, pull_high = 1'b0;
    mepr_data_s   dat = 7'h00;
    mepr_events_s ev = 13'h0000;
    logic         pready, pslverr, irq, rd_err, line_a, line_b, pa_out, pa_oe, pb_out, pb_oe;
    int           fail_count = 0;
    int           checks = 0;

    mepr_router #(.EV_W(13)) i_mepr_router (
        .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .data_in(dat), .events_in(ev),
        .accel_active(accel_active), .sample_mark_input(sample_mark_input), .event_pin_a_out(pa_out),
        .event_pin_a_oe(pa_oe), .event_pin_b_out(pb_out), .event_pin_b_oe(pb_oe), .irq(irq));
    mepr_host_lines i_mepr_host_lines (.pin_a_out(pa_out), .pin_a_oe(pa_oe), .pin_b_out(pb_out),
        .pin_b_oe(pb_oe), .pull_high(pull_high), .line_a(line_a), .line_b(line_b));

    always #10 mclk = ~mclk;

    task automatic finish_test();
        if (fail_count == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // Bounded wait for ready; a hung slave ends the run
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge mclk);
            n++;
        end
        if (pready !== 1'b1)
        begin
            fail_count++;
            finish_test();
        end
        rd_val = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd_val, {24'h0, e});
    endtask

    task automatic pin_chk(input logic [7:0] c, input logic ea, input logic eb);
        chk({28'h0, pa_out, pa_oe, pb_out, pb_oe}, {28'h0, ea ^ c[0], ea | !c[1], eb ^ c[0], eb | !c[1]});
        chk({30'h0, line_a, line_b}, {30'h0, ea ^ c[0], eb ^ c[0]});
    endtask

    task automatic pulse_ev(input logic [12:0] v);
        ev <= v;
        tick(1);
        ev <= 13'h0000;
        tick(4);
    endtask

    // One ready edge, then count cycles with pin a asserted
    task automatic ready_count(input logic [31:0] e);
        int k;
        k = 0;
        dat <= 7'h01;
        @(posedge mclk);
        dat <= 7'h00;
        repeat (8)
        begin
            @(posedge mclk);
            if (pa_out === 1'b1) k++;
        end
        chk(k, e);
    endtask

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial
    begin
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        foreach (ROWS[i])
        begin
            wr(`MEPR_OFF_A_DATA, ROWS[i].ad);
            wr(`MEPR_OFF_A_MOTION, ROWS[i].am);
            wr(`MEPR_OFF_B_DATA, ROWS[i].bd);
            wr(`MEPR_OFF_B_MOTION, ROWS[i].bm);
            wr(`MEPR_OFF_CTRL, ROWS[i].ctl);
            rd(`MEPR_OFF_A_MOTION, ROWS[i].am);
            dat <= ROWS[i].dat;
            ev <= ROWS[i].ev;
            pull_high <= ROWS[i].ctl[0];
            tick(4);
            pin_chk(ROWS[i].ctl, ROWS[i].ea, ROWS[i].eb);
            dat <= 7'h00;
            ev <= 13'h0000;
        end
        // Latched wake-up outlives its condition until its source is read
        rd(`MEPR_OFF_SRC_WU, 8'h07);
        wr(`MEPR_OFF_IRQ_STAT, 8'h07);
        wr(`MEPR_OFF_IRQ_MASK, 8'h01);
        wr(`MEPR_OFF_A_MOTION, 8'h20);
        wr(`MEPR_OFF_CTRL, 8'h24);
        pulse_ev(13'h0020);
        pin_chk(8'h24, 1'b1, 1'b0);
        chk({31'h0, irq}, 32'h1);
        rd(`MEPR_OFF_SRC_WU, 8'h02);
        tick(3);
        pin_chk(8'h24, 1'b0, 1'b0);
        wr(`MEPR_OFF_IRQ_STAT, 8'h01);
        tick(2);
        chk({31'h0, irq}, 32'h0);
        wr(`MEPR_OFF_A_MOTION, 8'h00);
        pulse_ev(13'h0008);
        pin_chk(8'h24, 1'b0, 1'b0);
        rd(`MEPR_OFF_SRC_TAP, 8'h03);
        wr(`MEPR_OFF_CTRL, 8'h20);
        wr(`MEPR_OFF_A_MOTION, 8'h20);
        accel_active <= 1'b0;
        ev <= 13'h0020;
        tick(4);
        pin_chk(8'h20, 1'b0, 1'b0);
        accel_active <= 1'b1;
        tick(4);
        pin_chk(8'h20, 1'b1, 1'b0);
        ev <= 13'h0000;
        // Gated ready: nothing before a mark, one pulse after it, then nothing
        wr(`MEPR_OFF_A_DATA, 8'h01);
        wr(`MEPR_OFF_CTRL, 8'h50);
        ready_count(32'h0);
        sample_mark_input <= 1'b0;
        tick(3);
        sample_mark_input <= 1'b1;
        tick(5);
        ready_count(32'h1);
        ready_count(32'h0);
        wr(`MEPR_OFF_CTRL, 8'hd0);
        sample_mark_input <= 1'b0;
        tick(5);
        ready_count(32'h1);
        apb(1'b0, 8'h30, 32'h0);
        chk({31'h0, rd_err}, 32'h1);
        chk(rd_val, 32'h0);
        rst_n <= 1'b0;
        tick(2);
        rst_n <= 1'b1;
        for (int a = 0; a <= 16; a += 4)
            rd(8'(a), 8'h00);
        pin_chk(8'h00, 1'b0, 1'b0);
        finish_test();
    end
endmodule
